/* shared/i2c_pkg.sv */
package i2c_pkg;
	// Mode codes on the mode select bits.
	localparam logic [3:0] MODE_SLV7     = 4'h6;
	localparam logic [3:0] MODE_SLV10    = 4'h7;
	localparam logic [3:0] MODE_MST      = 4'h8;
	localparam logic [3:0] MODE_FWMST    = 4'hB;
	localparam logic [3:0] MODE_SLV7_SS  = 4'hE;
	localparam logic [3:0] MODE_SLV10_SS = 4'hF;
	localparam logic [7:0] GC_ADDR       = 8'h00;
	localparam logic [4:0] TEN_HDR       = 5'h1E;
	localparam logic [3:0] BIT_LAST      = 4'h7;
	localparam logic [3:0] BIT_ACK       = 4'h8;
	localparam logic [7:0] OWN_RST       = 8'h00;
	localparam logic [7:0] BUF_RST       = 8'h00;
	localparam int         CLK_NS        = 5;
	localparam int         T_START_NS    = 600;
	localparam int         T_START_CYC   = (T_START_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] START_CYC     = 8'(T_START_CYC);
	localparam logic [7:0] CNT_ZERO      = 8'h00;
	localparam logic [7:0] CNT_ONE       = 8'h01;
	typedef enum logic [2:0]
	{
		ST_IDLE    = 3'h0,
		ST_ADDR    = 3'h1,
		ST_ADDR_LO = 3'h3,
		ST_RX      = 3'h2,
		ST_TX      = 3'h6,
		ST_IGN     = 3'h7
	} slave_st_t;
	typedef enum logic [1:0]
	{
		M_IDLE = 2'h0,
		M_SDA  = 2'h1,
		M_SCL  = 2'h3
	} mst_st_t;
endpackage

/* shared/link_if.sv */
`timescale 1ns/10ps
interface link_if;
	logic       scl_in;
	logic       sda_in;
	logic       scl_oe;
	logic       sda_oe;
	logic       hold;
	logic       ack;
	logic       tx_en;
	logic       msda;
	logic       mscl;
	logic       ce;
	logic [7:0] tx_byte;
	logic [7:0] rx_byte;
	logic       start_t;
	logic       stop_t;
	logic       byte_t;
	logic       fall9_t;
	logic       nack;
	modport ctrl (output scl_in, sda_in, hold, ack, tx_en, msda, mscl, ce, tx_byte,
		input scl_oe, sda_oe, rx_byte, start_t, stop_t, byte_t, fall9_t, nack);
	modport line (input scl_in, sda_in, hold, ack, tx_en, msda, mscl, ce, tx_byte,
		output scl_oe, sda_oe, rx_byte, start_t, stop_t, byte_t, fall9_t, nack);
endinterface

/* core/i2c_line_engine.sv */
`timescale 1ns/10ps
module i2c_line_engine
	import i2c_pkg::*;
(
	input wire logic lclk,
	input wire logic nrst,
	link_if.line     lk
);
	logic [1:0] scl_q;
	logic [1:0] sda_q;
	logic [5:0] ctl_q1;
	logic [5:0] ctl_q2;
	logic       scl;
	logic       sda;
	logic       scl_p;
	logic       sda_p;
	logic       active_r;
	logic       lead_r;
	logic       sda_drv_r;
	logic       hold_s;
	logic       ack_s;
	logic       tx_s;
	logic       msda_s;
	logic       mscl_s;
	logic       ce_s;
	logic       rise;
	logic       fall;
	logic       start_c;
	logic       stop_c;
	logic [3:0] cnt_r;
	logic [7:0] sr_r;

	// Pins and control levels are foreign to this clock, so only the second stage is read.
	always_ff @(posedge lclk or negedge nrst)
	begin
		if (!nrst)
		begin
			scl_q <= 2'h3;
			sda_q <= 2'h3;
			ctl_q1 <= 6'h00;
			ctl_q2 <= 6'h00;
		end
		else
		begin
			scl_q <= {scl_q[0], lk.scl_in};
			sda_q <= {sda_q[0], lk.sda_in};
			ctl_q1 <= {lk.hold, lk.ack, lk.tx_en, lk.msda, lk.mscl, lk.ce};
			ctl_q2 <= ctl_q1;
		end
	end

	assign scl = scl_q[1];
	assign sda = sda_q[1];
	assign {hold_s, ack_s, tx_s, msda_s, mscl_s, ce_s} = ctl_q2;
	assign rise = scl & ~scl_p;
	assign fall = ~scl & scl_p;
	assign start_c = scl & scl_p & sda_p & ~sda;
	assign stop_c = scl & scl_p & ~sda_p & sda;

	// Events leave as toggles; the received byte stays put until the next eighth bit.
	always_ff @(posedge lclk or negedge nrst)
	begin
		if (!nrst)
		begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			active_r <= 1'b0;
			lead_r <= 1'b0;
			cnt_r <= 4'h0;
			sr_r <= 8'h00;
			lk.rx_byte <= 8'h00;
			lk.start_t <= 1'b0;
			lk.stop_t <= 1'b0;
			lk.byte_t <= 1'b0;
			lk.fall9_t <= 1'b0;
			lk.nack <= 1'b0;
		end
		else if (ce_s)
		begin
			scl_p <= scl;
			sda_p <= sda;
			if (start_c)
			begin
				active_r <= 1'b1;
				lead_r <= 1'b1;
				cnt_r <= 4'h0;
				lk.start_t <= ~lk.start_t;
			end
			else if (stop_c)
			begin
				active_r <= 1'b0;
				lk.stop_t <= ~lk.stop_t;
			end
			// The fall that closes a start is no bit; counting it would shift every byte by one.
			else if (lead_r && fall)
				lead_r <= 1'b0;
			else if (active_r && rise && cnt_r <= BIT_LAST)
			begin
				sr_r <= {sr_r[6:0], sda};
				if (cnt_r == BIT_LAST)
				begin
					lk.rx_byte <= {sr_r[6:0], sda};
					lk.byte_t <= ~lk.byte_t;
				end
			end
			else if (active_r && rise)
				lk.nack <= sda;
			else if (active_r && fall && cnt_r == BIT_ACK)
			begin
				cnt_r <= 4'h0;
				lk.fall9_t <= ~lk.fall9_t;
			end
			else if (active_r && fall)
				cnt_r <= cnt_r + 4'h1;
		end
	end

	// SDA only changes while SCL is low, so data is valid through the high time.
	always_ff @(posedge lclk or negedge nrst)
	begin
		if (!nrst)
		begin
			sda_drv_r <= 1'b0;
			lk.sda_oe <= 1'b0;
			lk.scl_oe <= 1'b0;
		end
		else if (ce_s)
		begin
			if (!active_r)
				sda_drv_r <= 1'b0;
			else if (!scl && cnt_r == BIT_ACK)
				sda_drv_r <= ack_s;
			else if (!scl)
				sda_drv_r <= tx_s & ~lk.tx_byte[3'(BIT_LAST - cnt_r)];
			lk.sda_oe <= sda_drv_r | msda_s;
			lk.scl_oe <= mscl_s | (hold_s & (lk.scl_oe | ~scl));
		end
	end
endmodule

/* core/i2c_slave_port.sv */
`timescale 1ns/10ps
// Summary of operation
// - 7-bit receive with stretching: full buffer at ninth fall clears release, holds SCL.
// - Buffer already read before ninth fall: release stays set, no stretch.
// - Software setting release always takes effect, whatever the buffer holds.
// - 10-bit write address bytes stretch on address-update without clearing release.
// - Address-update sets after upper address byte with write and after the matching low byte.
// - Writing the own address register releases an address stretch.
// - Buffer-full stretching applies to data bytes only, never address bytes.
// - 7-bit transmit: empty buffer at ninth fall clears release regardless of stretch enable.
// - Transmit data loaded before ninth fall: release stays set, no stretch.
// - 10-bit transmit: third header byte with read, then buffer-full governs stretching.
// - Cleared release drives SCL low only after SCL was sampled low.
// - SCL stays low until release is set and all others let it go.
// - With general call enabled, the all-zero write address also matches.
// - General call loads buffer, sets full on eighth bit, flag on ninth fall.
// - 10-bit mode accepts general call without low byte or address-update.
// - Start-seen and stop-seen clear at reset and while the port is disabled.
// - Master mode: buffer write during a start is dropped and flags collision.
// - Master mode flags start, stop, repeated start, byte done and acknowledge.
// - Master mode comes from mode bits with enable; hardware drives both lines in MODE_MST only.
// - Stretch enable holds SCL low after a received data byte that finds the buffer full.
module i2c_slave_port
	import i2c_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       NRST,
	input  wire logic       CE,
	input  wire logic       LCLK,
	input  wire logic       SCL_I,
	output wire logic       SCL_O,
	output wire logic       SCL_OE,
	input  wire logic       SDA_I,
	output wire logic       SDA_O,
	output wire logic       SDA_OE,
	input  wire logic       PORT_EN,
	input  wire logic [3:0] MODE_SEL,
	input  wire logic       STRETCH_EN,
	input  wire logic       GCALL_EN,
	input  wire logic       CLK_RELEASE_SET,
	input  wire logic       OWN_ADDR_WR,
	input  wire logic [7:0] OWN_ADDR_DATA,
	input  wire logic       BUF_WR,
	input  wire logic [7:0] BUF_WDATA,
	input  wire logic       BUF_RD,
	input  wire logic       IRQ_FLAG_CLR,
	input  wire logic       WR_COLL_CLR,
	input  wire logic       START_REQ,
	output wire logic [7:0] BUF_RDATA,
	output wire logic       BUF_FULL,
	output wire logic       CLK_RELEASE,
	output wire logic       ADDR_UPD,
	output wire logic       RW,
	output wire logic       IRQ_FLAG,
	output wire logic       WR_COLL,
	output wire logic       START_SEEN,
	output wire logic       STOP_SEEN,
	output wire logic       START_BUSY
);
	link_if lk ();

	logic [3:0] ev_q1;
	logic [3:0] ev_q2;
	logic [3:0] ev_q3;
	logic [3:0] ev;
	logic       ev_start;
	logic       ev_stop;
	logic       ev_byte;
	logic       ev_fall9;
	logic [7:0] rx;
	logic       is_slave;
	logic       is_mst;
	logic       ten;
	logic       ss_int;
	logic       a_hit;
	logic       gc_hit;
	logic       acc;
	logic       upd_set;
	logic       rel_clr;
	logic       wr_ok;
	logic       ld_rx;
	logic       pif_set;
	logic       start_go;
	slave_st_t  st_r;
	slave_st_t  st_nxt;
	mst_st_t    mst_r;
	logic [7:0] buf_r;
	logic [7:0] own_r;
	logic [7:0] mcnt_r;
	logic       full_r;
	logic       rel_r;
	logic       upd_r;
	logic       ahold_r;
	logic       hold_r;
	logic       ack_r;
	logic       addr_r;
	logic       ten_ok_r;
	logic       rw_r;
	logic       pif_r;
	logic       coll_r;
	logic       sseen_r;
	logic       pseen_r;
	logic       mbusy_r;
	logic       msda_r;
	logic       mscl_r;

	assign lk.scl_in = SCL_I;
	assign lk.sda_in = SDA_I;
	assign lk.hold = hold_r;
	assign lk.ack = ack_r;
	assign lk.tx_en = (st_r == ST_TX);
	assign lk.tx_byte = buf_r;
	assign lk.msda = msda_r;
	assign lk.mscl = mscl_r;
	assign lk.ce = CE;

	i2c_line_engine u_line
	(
		.lclk (LCLK),
		.nrst (NRST),
		.lk   (lk)
	);

	// Line events arrive as toggles; an edge of the synchronised toggle is one event.
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			ev_q1 <= 4'h0;
			ev_q2 <= 4'h0;
			ev_q3 <= 4'h0;
		end
		else if (CE)
		begin
			ev_q1 <= {lk.start_t, lk.stop_t, lk.byte_t, lk.fall9_t};
			ev_q2 <= ev_q1;
			ev_q3 <= ev_q2;
		end
	end

	assign ev = (ev_q2 ^ ev_q3) & {4{CE}};
	assign {ev_start, ev_stop, ev_byte, ev_fall9} = ev;
	assign rx = lk.rx_byte;
	assign ten = (MODE_SEL == MODE_SLV10) || (MODE_SEL == MODE_SLV10_SS);
	assign ss_int = (MODE_SEL == MODE_SLV7_SS) || (MODE_SEL == MODE_SLV10_SS);
	assign is_slave = PORT_EN && (ten || ss_int || MODE_SEL == MODE_SLV7);
	assign is_mst = PORT_EN && (MODE_SEL == MODE_MST || MODE_SEL == MODE_FWMST);
	assign gc_hit = GCALL_EN && rx == GC_ADDR;
	assign a_hit = rx[7:1] == own_r[7:1] && (!ten || rx[7:3] == TEN_HDR);

	always_comb
	begin
		st_nxt = st_r;
		acc = 1'b0;
		upd_set = 1'b0;
		if (!is_slave)
			st_nxt = ST_IDLE;
		else if (ev_start)
			st_nxt = ST_ADDR;
		else if (ev_stop)
			st_nxt = ST_IDLE;
		else if (ev_byte)
		begin
			if (st_r == ST_ADDR && gc_hit)
			begin
				st_nxt = ST_RX;
				acc = 1'b1;
			end
			else if (st_r == ST_ADDR && a_hit && !ten)
			begin
				st_nxt = rx[0] ? ST_TX : ST_RX;
				acc = 1'b1;
			end
			else if (st_r == ST_ADDR && a_hit && !rx[0])
			begin
				st_nxt = ST_ADDR_LO;
				acc = 1'b1;
				upd_set = 1'b1;
			end
			else if (st_r == ST_ADDR && a_hit && ten_ok_r)
			begin
				st_nxt = ST_TX;
				acc = 1'b1;
			end
			else if (st_r == ST_ADDR_LO && rx == own_r)
			begin
				st_nxt = ST_RX;
				acc = 1'b1;
				upd_set = 1'b1;
			end
			else if (st_r == ST_RX)
				acc = 1'b1;
			else if (st_r != ST_TX)
				st_nxt = ST_IGN;
		end
		else if (ev_fall9 && st_r == ST_TX && lk.nack)
			st_nxt = ST_IGN;
	end

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			st_r <= ST_IDLE;
			ten_ok_r <= 1'b0;
			addr_r <= 1'b0;
			rw_r <= 1'b0;
			ack_r <= 1'b0;
		end
		else if (CE)
		begin
			st_r <= st_nxt;
			if (!is_slave || ev_stop)
				ten_ok_r <= 1'b0;
			else if (ev_byte && st_r == ST_ADDR_LO)
				ten_ok_r <= acc;
			if (ev_byte)
				addr_r <= (st_r == ST_ADDR || st_r == ST_ADDR_LO);
			if (ev_byte && acc && st_r == ST_ADDR)
				rw_r <= rx[0];
			if (ev_byte)
				ack_r <= acc && !full_r;
			else if (ev_fall9)
				ack_r <= 1'b0;
		end
	end

	// The address of a read is kept in the buffer but leaves it empty, so transmit stretches.
	assign ld_rx = ev_byte && acc && !full_r && st_r != ST_TX;
	assign wr_ok = BUF_WR && !(is_mst && mbusy_r);

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			buf_r <= BUF_RST;
			full_r <= 1'b0;
			own_r <= OWN_RST;
			coll_r <= 1'b0;
		end
		else if (CE)
		begin
			if (wr_ok)
				buf_r <= BUF_WDATA;
			else if (ld_rx)
				buf_r <= rx;
			if (wr_ok || (ld_rx && st_nxt != ST_TX))
				full_r <= 1'b1;
			else if (BUF_RD || (ev_byte && st_r == ST_TX))
				full_r <= 1'b0;
			if (OWN_ADDR_WR)
				own_r <= OWN_ADDR_DATA;
			if (BUF_WR && !wr_ok)
				coll_r <= 1'b1;
			else if (WR_COLL_CLR)
				coll_r <= 1'b0;
		end
	end

	// Buffer-full stretching looks only at data bytes; address bytes use address-update.
	assign rel_clr = ev_fall9 && is_slave
		&& ((st_r == ST_RX && !addr_r && STRETCH_EN && full_r)
		|| (st_r == ST_TX && !lk.nack && !full_r));

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			rel_r <= 1'b1;
			upd_r <= 1'b0;
			ahold_r <= 1'b0;
			hold_r <= 1'b0;
		end
		else if (CE)
		begin
			if (CLK_RELEASE_SET)
				rel_r <= 1'b1;
			else if (rel_clr)
				rel_r <= 1'b0;
			if (upd_set)
				upd_r <= 1'b1;
			else if (OWN_ADDR_WR)
				upd_r <= 1'b0;
			if (ev_fall9 && upd_r && is_slave)
				ahold_r <= 1'b1;
			else if (OWN_ADDR_WR || !is_slave)
				ahold_r <= 1'b0;
			hold_r <= is_slave && (!rel_r || ahold_r);
		end
	end

	assign pif_set = (ev_fall9 && (ack_r || st_r == ST_TX))
		|| (ss_int && is_slave && (ev_start || ev_stop))
		|| (is_mst && (ev_start || ev_stop || ev_fall9));

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			pif_r <= 1'b0;
			sseen_r <= 1'b0;
			pseen_r <= 1'b0;
		end
		else if (CE)
		begin
			if (pif_set)
				pif_r <= 1'b1;
			else if (IRQ_FLAG_CLR)
				pif_r <= 1'b0;
			if (!PORT_EN)
			begin
				sseen_r <= 1'b0;
				pseen_r <= 1'b0;
			end
			else if (ev_start)
			begin
				sseen_r <= 1'b1;
				pseen_r <= 1'b0;
			end
			else if (ev_stop)
			begin
				sseen_r <= 1'b0;
				pseen_r <= 1'b1;
			end
		end
	end

	// A start pulls SDA low, waits, then pulls SCL low and leaves both held for the transfer.
	assign start_go = START_REQ && PORT_EN && MODE_SEL == MODE_MST && !mbusy_r;

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			mst_r <= M_IDLE;
			mcnt_r <= CNT_ZERO;
			mbusy_r <= 1'b0;
			msda_r <= 1'b0;
			mscl_r <= 1'b0;
		end
		else if (CE)
		begin
			if (!(PORT_EN && MODE_SEL == MODE_MST))
			begin
				mst_r <= M_IDLE;
				mbusy_r <= 1'b0;
				msda_r <= 1'b0;
				mscl_r <= 1'b0;
			end
			else
			begin
				case (mst_r)
					M_IDLE:
					begin
						if (start_go)
						begin
							mst_r <= M_SDA;
							mcnt_r <= START_CYC;
							mbusy_r <= 1'b1;
							msda_r <= 1'b1;
							mscl_r <= 1'b0;
						end
					end
					M_SDA:
					begin
						if (mcnt_r == CNT_ONE)
						begin
							mst_r <= M_SCL;
							mcnt_r <= START_CYC;
							mscl_r <= 1'b1;
						end
						else
							mcnt_r <= mcnt_r - CNT_ONE;
					end
					M_SCL:
					begin
						if (mcnt_r == CNT_ONE)
						begin
							mst_r <= M_IDLE;
							mbusy_r <= 1'b0;
						end
						else
							mcnt_r <= mcnt_r - CNT_ONE;
					end
					default:
						mst_r <= M_IDLE;
				endcase
			end
		end
	end

	assign SCL_O = 1'b0;
	assign SDA_O = 1'b0;
	assign SCL_OE = lk.scl_oe;
	assign SDA_OE = lk.sda_oe;
	assign BUF_RDATA = buf_r;
	assign BUF_FULL = full_r;
	assign CLK_RELEASE = rel_r;
	assign ADDR_UPD = upd_r;
	assign RW = rw_r;
	assign IRQ_FLAG = pif_r;
	assign WR_COLL = coll_r;
	assign START_SEEN = sseen_r;
	assign STOP_SEEN = pseen_r;
	assign START_BUSY = mbusy_r;

	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST || !CE);

	a_rx_stretch: assert property (ev_fall9 && is_slave && st_r == ST_RX && !addr_r
		&& STRETCH_EN && full_r && !CLK_RELEASE_SET |=> !rel_r ##1 hold_r)
		else $error("receive stretch missing");
	a_rx_nostretch: assert property (ev_fall9 && st_r == ST_RX && !full_r && rel_r |=> rel_r)
		else $error("release cleared with empty buffer");
	a_rel_set: assert property (CLK_RELEASE_SET |=> rel_r)
		else $error("release set ignored");
	a_upd_hold: assert property (ev_fall9 && upd_r && is_slave && !OWN_ADDR_WR
		|=> ahold_r && rel_r == $past(rel_r))
		else $error("address stretch wrong");
	a_upd_low: assert property (ev_byte && is_slave && st_r == ST_ADDR_LO && rx == own_r
		|=> upd_r && st_r == ST_RX)
		else $error("address update not set");
	a_own_release: assert property (OWN_ADDR_WR && !upd_set && is_slave
		|=> !ahold_r && !upd_r ##1 !hold_r || !rel_r)
		else $error("own address write kept hold");
	a_addr_keep: assert property (ev_fall9 && addr_r && st_r != ST_TX && rel_r
		&& !CLK_RELEASE_SET |=> rel_r)
		else $error("address byte cleared release");
	a_tx_stretch: assert property (ev_fall9 && is_slave && st_r == ST_TX && !lk.nack
		&& !full_r && !CLK_RELEASE_SET |=> !rel_r)
		else $error("transmit stretch missing");
	a_tx_loaded: assert property (ev_fall9 && st_r == ST_TX && full_r && rel_r |=> rel_r)
		else $error("release cleared with loaded data");
	a_gc_accept: assert property (ev_byte && is_slave && st_r == ST_ADDR && gc_hit
		&& !full_r && !BUF_WR |=> full_r && buf_r == GC_ADDR && st_r == ST_RX && !$rose(upd_r))
		else $error("general call not taken");
	a_flags_off: assert property (!PORT_EN |=> !sseen_r && !pseen_r)
		else $error("start or stop flag survived disable");
	a_wr_coll: assert property (BUF_WR && is_mst && mbusy_r |=> coll_r && $stable(buf_r))
		else $error("write during start not discarded");
	a_mst_flag: assert property (is_mst && (ev_start || ev_stop || ev_fall9) |=> pif_r)
		else $error("master event flag missing");
	a_start_seq: assert property (start_go |=> mbusy_r && msda_r ##[1:300] !mbusy_r && mscl_r)
		else $error("start sequence did not complete");
endmodule

/* dv/bus_host.sv */
`timescale 1ns/10ps
module bus_host
(
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	output wire logic scl,
	output wire logic sda
);
	localparam int HALF = 250;
	logic m_scl_low = 1'b0;
	logic m_sda_low = 1'b0;
	// Both lines have pull-ups, so a released line reads high.
	assign scl = !(m_scl_low || scl_oe);
	assign sda = !(m_sda_low || sda_oe);
	// Waits out any stretch, but gives up so that a stuck line cannot hang the run.
	task automatic scl_high();
		int n;
		n = 0;
		m_scl_low = 1'b0;
		while (scl !== 1'b1 && n < 20000)
		begin
			#5;
			n++;
		end
		#HALF;
	endtask
	task automatic put_bit(input logic b, output logic r);
		#50;
		m_sda_low = !b;
		#(HALF - 50);
		scl_high();
		r = sda;
		m_scl_low = 1'b1;
	endtask
	task automatic start();
		m_sda_low = 1'b1;
		#HALF;
		m_scl_low = 1'b1;
	endtask
	task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
		output logic r9);
		for (int i = 7; i >= 0; i--)
			put_bit(d[i], q[i]);
		put_bit(b9, r9);
	endtask
	task automatic stop();
		#50;
		m_sda_low = 1'b1;
		#(HALF - 50);
		scl_high();
		m_sda_low = 1'b0;
		#HALF;
	endtask
	task automatic rstart();
		#50;
		m_sda_low = 1'b0;
		#(HALF - 50);
		scl_high();
		start();
	endtask
endmodule

/* dv/test_i2c_slave_port.sv */
`timescale 1ns/10ps
module test_i2c_slave_port
	import i2c_pkg::*;
;
	localparam logic [6:0] RD = 7'h01, REL = 7'h02, ICLR = 7'h04, WCLR = 7'h08;
	localparam logic [6:0] STRT = 7'h10, BWR = 7'h20, OWR = 7'h40;
	logic       CLK = 1'b0;
	logic       LCLK = 1'b0;
	logic       NRST = 1'b0;
	logic       CE = 1'b1;
	logic       PORT_EN = 1'b1;
	logic [3:0] MODE_SEL = MODE_SLV7_SS;
	logic       STRETCH_EN = 1'b1;
	logic       GCALL_EN = 1'b0;
	logic [7:0] OWN_ADDR_DATA = 8'h00;
	logic [7:0] BUF_WDATA = 8'h00;
	logic [6:0] stb = 7'h00;
	logic [7:0] lf = 8'h2C;
	logic [6:0] own;
	int         failures = 0;
	int         n_compared = 0;
	wire        CLK_RELEASE_SET, OWN_ADDR_WR, BUF_WR, BUF_RD, IRQ_FLAG_CLR, WR_COLL_CLR;
	wire        START_REQ, SCL_I, SDA_I, SCL_OE, SDA_OE, BUF_FULL, CLK_RELEASE, ADDR_UPD;
	wire        RW, IRQ_FLAG, WR_COLL, START_SEEN, STOP_SEEN, START_BUSY;
	wire  [7:0] BUF_RDATA;
	assign {OWN_ADDR_WR, BUF_WR, START_REQ, WR_COLL_CLR, IRQ_FLAG_CLR, CLK_RELEASE_SET, BUF_RD} = stb;
	i2c_slave_port u_i2c_slave_port
	(
		.CLK, .NRST, .CE, .LCLK, .SCL_I, .SCL_O(), .SCL_OE, .SDA_I, .SDA_O(), .SDA_OE,
		.PORT_EN, .MODE_SEL, .STRETCH_EN, .GCALL_EN, .CLK_RELEASE_SET, .OWN_ADDR_WR,
		.OWN_ADDR_DATA, .BUF_WR, .BUF_WDATA, .BUF_RD, .IRQ_FLAG_CLR, .WR_COLL_CLR, .START_REQ,
		.BUF_RDATA, .BUF_FULL, .CLK_RELEASE, .ADDR_UPD, .RW, .IRQ_FLAG, .WR_COLL, .START_SEEN,
		.STOP_SEEN, .START_BUSY
	);
	bus_host u_bus_host
	(
		.scl_oe(SCL_OE),
		.sda_oe(SDA_OE),
		.scl   (SCL_I),
		.sda   (SDA_I)
	);
	initial
	begin
		forever #2.5 CLK = ~CLK;
	end
	initial
	begin
		#1.7;
		forever #6 LCLK = ~LCLK;
	end
	function automatic logic [7:0] rnd();
		lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		return lf;
	endfunction
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("unexpected %s: expected %h seen %h", w, e, g);
			failures++;
		end
	endtask
	task automatic chk1(input string w, input logic e, input logic g);
		chk(w, {7'h00, e}, {7'h00, g});
	endtask
	task automatic pulse(input logic [6:0] m);
		@(negedge CLK);
		stb = m;
		@(negedge CLK);
		stb = 7'h00;
	endtask
	task automatic print_verdict();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr_frame(input logic early);
		logic [7:0] d;
		logic [7:0] q;
		logic       r9;
		d = rnd();
		u_bus_host.start();
		u_bus_host.xfer({own, 1'b0}, 1'b1, q, r9);
		#300;
		chk1("addr ack", 1'b0, r9);
		chk1("addr irq", 1'b1, IRQ_FLAG);
		chk1("start seen", 1'b1, START_SEEN);
		pulse(RD | ICLR);
		fork
			u_bus_host.xfer(d, 1'b1, q, r9);
			if (early)
			begin
				repeat (3000) if (BUF_FULL !== 1'b1) @(negedge CLK);
				pulse(RD);
			end
		join
		#300;
		chk("rx data", d, BUF_RDATA);
		chk1("release", early, CLK_RELEASE);
		chk1("scl hold", !early, SCL_OE);
		fork
			u_bus_host.stop();
			begin
				#400;
				chk1("scl line", early, SCL_I);
				pulse(REL);
				chk1("set release", 1'b1, CLK_RELEASE);
				pulse(RD);
			end
		join
		#300;
		chk1("stop seen", 1'b1, STOP_SEEN);
		$display("test write frame done");
	endtask
	initial
	begin
		#400000;
		failures++;
		print_verdict();
	end
	initial
	begin
		logic [7:0] d;
		logic [7:0] q;
		logic [7:0] hdr;
		logic [7:0] lo;
		logic       r9;
		repeat (5) @(negedge CLK);
		NRST = 1'b1;
		chk1("rst release", 1'b1, CLK_RELEASE);
		chk1("rst full", 1'b0, BUF_FULL);
		chk1("rst oe", 1'b0, SCL_OE);
		d = rnd();
		own = {2'b01, d[4:0]};
		OWN_ADDR_DATA = {own, 1'b0};
		pulse(OWR);
		repeat (8) @(negedge CLK);
		wr_frame(1'b0);
		wr_frame(1'b1);
		for (int i = 0; i < 3; i++)
		begin
			MODE_SEL = (i == 1) ? MODE_SLV10 : MODE_SLV7;
			GCALL_EN = (i != 2);
			pulse(ICLR);
			u_bus_host.start();
			u_bus_host.xfer(GC_ADDR, 1'b1, q, r9);
			#300;
			chk1("gc ack", i == 2, r9);
			chk1("gc irq", i != 2, IRQ_FLAG);
			chk1("gc full", i != 2, BUF_FULL);
			chk1("gc upd", 1'b0, ADDR_UPD);
			pulse(RD | ICLR);
			u_bus_host.stop();
		end
		$display("test general call done");
		STRETCH_EN = 1'b0;
		d = rnd();
		u_bus_host.start();
		u_bus_host.xfer({own, 1'b1}, 1'b1, q, r9);
		#300;
		chk1("rd ack", 1'b0, r9);
		chk1("rw", 1'b1, RW);
		chk1("tx stretch", 1'b0, CLK_RELEASE);
		BUF_WDATA = d;
		pulse(BWR | ICLR);
		pulse(REL);
		fork
			u_bus_host.xfer(8'hFF, 1'b0, q, r9);
			begin
				repeat (3000) if (BUF_FULL !== 1'b0) @(negedge CLK);
				BUF_WDATA = ~d;
				pulse(BWR);
			end
		join
		#300;
		chk("tx data", d, q);
		chk1("tx preload", 1'b1, CLK_RELEASE);
		u_bus_host.xfer(8'hFF, 1'b1, q, r9);
		chk("tx data2", ~d, q);
		u_bus_host.stop();
		$display("test transmit done");
		MODE_SEL = MODE_SLV10_SS;
		STRETCH_EN = 1'b1;
		lo = rnd();
		hdr = {TEN_HDR, lo[1:0], 1'b0};
		lo = rnd();
		OWN_ADDR_DATA = hdr;
		pulse(OWR | RD | ICLR);
		u_bus_host.start();
		u_bus_host.xfer(hdr, 1'b1, q, r9);
		#300;
		chk1("hdr upd", 1'b1, ADDR_UPD);
		chk1("hdr hold", 1'b1, SCL_OE);
		chk1("hdr release", 1'b1, CLK_RELEASE);
		OWN_ADDR_DATA = lo;
		pulse(OWR | RD | ICLR);
		#300;
		chk1("own wr", 1'b0, SCL_OE);
		u_bus_host.xfer(lo, 1'b1, q, r9);
		#300;
		chk1("lo upd", 1'b1, ADDR_UPD);
		chk1("lo release", 1'b1, CLK_RELEASE);
		OWN_ADDR_DATA = hdr;
		pulse(OWR | RD | ICLR);
		d = rnd();
		u_bus_host.xfer(d, 1'b1, q, r9);
		#300;
		chk("10b data", d, BUF_RDATA);
		chk1("10b stretch", 1'b0, CLK_RELEASE);
		pulse(REL | RD);
		u_bus_host.rstart();
		u_bus_host.xfer({hdr[7:1], 1'b1}, 1'b1, q, r9);
		#300;
		chk1("10b rd ack", 1'b0, r9);
		chk1("10b rw", 1'b1, RW);
		chk1("10b rd upd", 1'b0, ADDR_UPD);
		chk1("10b tx stretch", 1'b0, CLK_RELEASE);
		pulse(REL);
		u_bus_host.stop();
		#300;
		chk1("10b stop", 1'b1, STOP_SEEN);
		PORT_EN = 1'b0;
		repeat (4) @(negedge CLK);
		chk1("off start", 1'b0, START_SEEN);
		chk1("off stop", 1'b0, STOP_SEEN);
		$display("test ten bit done");
		PORT_EN = 1'b1;
		MODE_SEL = MODE_MST;
		pulse(ICLR);
		pulse(STRT);
		chk1("busy", 1'b1, START_BUSY);
		BUF_WDATA = ~hdr;
		pulse(BWR);
		chk1("collision", 1'b1, WR_COLL);
		chk("buf kept", {hdr[7:1], 1'b1}, BUF_RDATA);
		repeat (300) @(negedge CLK);
		chk1("start irq", 1'b1, IRQ_FLAG);
		chk1("scl drive", 1'b1, SCL_OE);
		chk1("sda drive", 1'b1, SDA_OE);
		pulse(WCLR);
		chk1("coll clr", 1'b0, WR_COLL);
		$display("test master done");
		print_verdict();
	end
endmodule
